// file: shared/pprx_pkg.sv
package pprx_pkg;
  localparam int unsigned PPRX_CLK_MHZ = 100;
  // Times in ns as printed, counts derived (least rounds up, longest down)
  localparam int unsigned PPRX_STROBE_MIN_NS = 500;
  localparam int unsigned PPRX_ACK_NS = 5000;
  localparam int unsigned PPRX_INIT_MIN_NS = 50000;
  localparam int unsigned PPRX_CPS_MAX = 1000;
  localparam int unsigned PPRX_STROBE_CYC = (PPRX_STROBE_MIN_NS * PPRX_CLK_MHZ + 999) / 1000;
  localparam int unsigned PPRX_ACK_CYC = (PPRX_ACK_NS * PPRX_CLK_MHZ) / 1000;
  localparam int unsigned PPRX_INIT_CYC = (PPRX_INIT_MIN_NS * PPRX_CLK_MHZ + 999) / 1000;
  localparam int unsigned PPRX_BYTE_GAP_CYC = (PPRX_CLK_MHZ * 1000000) / PPRX_CPS_MAX;
  localparam int unsigned PPRX_DATA_W = 8;
  localparam int unsigned PPRX_CNT_W = 24;
  localparam logic [7:0] PPRX_LF_CODE = 8'h0a;
  localparam logic [7:0] PPRX_CR_CODE = 8'h0d;
  localparam logic [23:0] PPRX_CNT_ZERO = 24'h000000;
  localparam logic [23:0] PPRX_CNT_ONE = 24'h000001;
endpackage

// file: shared/pprx_if.sv
`timescale 1ns/1ns
interface pprx_if;
  logic strobe_n;
  logic [7:0] data;
  logic init_n;
  logic auto_feed_n;
  logic select_request_n;
  logic byte_received_pulse_n;
  logic busy;
  logic paper_out;
  logic selected_status;
  logic error_n;
  modport printer (
    input strobe_n, data, init_n, auto_feed_n, select_request_n,
    output byte_received_pulse_n, busy, paper_out, selected_status, error_n
  );
  modport host (
    output strobe_n, data, init_n, auto_feed_n, select_request_n,
    input byte_received_pulse_n, busy, paper_out, selected_status, error_n
  );
endinterface

// file: core/pprx_printer.sv
`timescale 1ns/1ns
// How it works
// - Strobe idles high; byte latched while low
// - Host drives eight data bits, high is one
// - Low acknowledge pulse after each byte
// - Busy high during entry, print, offline, error; here print raises busy only once the two-entry buffer is full
// - Paper-out output high when paper runs out
// - Selected-status output shows selected state
// - Auto-feed low adds line feed after line
// - Switch forces auto-feed low internally
// - Long init low resets controller, empties buffer
// - Error output low on paper end, offline, error
// - Accept data only with select request low or select forced
// - Host sends only after acknowledge or busy low
// - Host keeps under maximum byte rate
module pprx_printer #(
  parameter int unsigned ACK_CYC = pprx_pkg::PPRX_ACK_CYC,
  parameter int unsigned INIT_CYC = pprx_pkg::PPRX_INIT_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  pprx_if.printer link,
  input wire logic auto_feed_forced,
  input wire logic select_forced,
  input wire logic paper_empty,
  input wire logic online,
  input wire logic fault,
  output logic [7:0] print_data,
  output logic print_valid,
  output logic print_line_feed,
  input wire logic print_ready
);
  import pprx_pkg::*;

  // Counts must fit the 24-bit counters
  if (ACK_CYC < 1 || INIT_CYC < 1 || ACK_CYC >= (1 << PPRX_CNT_W)
      || INIT_CYC >= (1 << PPRX_CNT_W)) begin : g_bad_count
    $error("pprx_printer: bad count parameter");
  end

  typedef enum logic [1:0] {
    PPRX_IDLE = 2'b00,
    PPRX_ENTRY = 2'b01,
    PPRX_STORE = 2'b10,
    PPRX_ACK = 2'b11
  } pprx_state_t;

  pprx_state_t state;
  pprx_state_t next_state;
  logic [23:0] ack_cnt;
  logic [23:0] init_cnt;
  logic [7:0] latch;
  logic feed_pending;
  logic busy;
  logic ack_n;
  logic paper_out;
  logic selected;
  logic error_n;
  // Two-entry buffer toward the print engine
  logic [7:0] buf_data [2];
  logic buf_lf [2];
  logic [1:0] buf_cnt;
  logic buf_wp;
  logic buf_rp;
  logic [7:0] out_data;
  logic out_valid;
  logic out_lf;

  wire select_eff_n = link.select_request_n & ~select_forced;
  wire auto_eff_n = link.auto_feed_n & ~auto_feed_forced;
  wire is_online = online & ~select_eff_n;
  wire has_error = fault | paper_empty;
  wire buf_full = (buf_cnt == 2'd2);
  wire buf_empty = (buf_cnt == 2'd0);
  wire can_accept = is_online & ~has_error & ~buf_full;
  // Init must stay low for INIT_CYC cycles before it takes effect
  wire init_fire = (init_cnt == INIT_CYC[23:0] - PPRX_CNT_ONE) & ~link.init_n;
  wire out_take = ~out_valid | print_ready;
  wire buf_pop = ~buf_empty & out_take;
  wire buf_push = (state == PPRX_STORE) & ~buf_full;
  wire push_lf = ~auto_eff_n & (latch == PPRX_CR_CODE);
  wire ack_done = (ack_cnt == ACK_CYC[23:0] - PPRX_CNT_ONE);

  always_comb begin
    next_state = state;
    case (state)
      // Strobe low starts entry only when able to accept
      PPRX_IDLE: begin
        if (~link.strobe_n & can_accept) begin
          next_state = PPRX_ENTRY;
        end
      end
      // Keep latching until the strobe rises
      PPRX_ENTRY: begin
        if (link.strobe_n) begin
          next_state = PPRX_STORE;
        end
      end
      PPRX_STORE: begin
        if (~buf_full) begin
          next_state = PPRX_ACK;
        end
      end
      PPRX_ACK: begin
        if (ack_done) begin
          next_state = PPRX_IDLE;
        end
      end
      default: next_state = PPRX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      init_cnt <= PPRX_CNT_ZERO;
    end else if (link.init_n) begin
      init_cnt <= PPRX_CNT_ZERO;
    end else if (!init_fire) begin
      init_cnt <= init_cnt + PPRX_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= PPRX_IDLE;
    end else if (init_fire) begin
      state <= PPRX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      latch <= 8'h00;
    end else if ((state == PPRX_ENTRY || next_state == PPRX_ENTRY) && ~link.strobe_n) begin
      latch <= link.data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_cnt <= PPRX_CNT_ZERO;
    end else if (state != PPRX_ACK || ack_done) begin
      ack_cnt <= PPRX_CNT_ZERO;
    end else begin
      ack_cnt <= ack_cnt + PPRX_CNT_ONE;
    end
  end

  // Busy released with the acknowledge end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_n <= 1'b1;
      busy <= 1'b1;
    end else begin
      ack_n <= ~(next_state == PPRX_ACK) | init_fire;
      // Busy whenever unable to take data
      busy <= (next_state != PPRX_IDLE) | ~can_accept | init_fire;
    end
  end

  // Error low on paper end, offline, error
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      paper_out <= 1'b0;
      selected <= 1'b0;
      error_n <= 1'b1;
    end else begin
      paper_out <= paper_empty;
      selected <= is_online;
      error_n <= ~(paper_empty | ~is_online | fault);
    end
  end

  // Line feed marked after carriage return
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      buf_cnt <= 2'd0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_data[0] <= 8'h00;
      buf_data[1] <= 8'h00;
      buf_lf[0] <= 1'b0;
      buf_lf[1] <= 1'b0;
    end else if (init_fire) begin
      buf_cnt <= 2'd0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_data[buf_wp] <= latch;
        buf_lf[buf_wp] <= push_lf;
        buf_wp <= ~buf_wp;
      end
      if (buf_pop) begin
        buf_rp <= ~buf_rp;
      end
      buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_lf <= 1'b0;
    end else if (init_fire) begin
      out_valid <= 1'b0;
    end else if (out_take) begin
      out_valid <= buf_pop;
      out_data <= buf_data[buf_rp];
      out_lf <= buf_lf[buf_rp];
    end
  end

  assign link.byte_received_pulse_n = ack_n;
  assign link.busy = busy;
  assign link.paper_out = paper_out;
  assign link.selected_status = selected;
  assign link.error_n = error_n;
  assign print_data = out_data;
  assign print_valid = out_valid;
  assign print_line_feed = out_lf;
endmodule

// file: core/pprx_host.sv
`timescale 1ns/1ns
module pprx_host #(
  parameter int unsigned STROBE_CYC = pprx_pkg::PPRX_STROBE_CYC,
  parameter int unsigned INIT_CYC = pprx_pkg::PPRX_INIT_CYC,
  parameter int unsigned GAP_CYC = pprx_pkg::PPRX_BYTE_GAP_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  pprx_if.host link,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic init_req,
  input wire logic auto_feed_req,
  input wire logic select_req
);
  import pprx_pkg::*;

  // Gap must cover the strobe; gap and init counts fit the 24-bit counters
  if (STROBE_CYC < 1 || INIT_CYC < 1 || GAP_CYC <= STROBE_CYC + 2
      || GAP_CYC >= (1 << PPRX_CNT_W) || INIT_CYC >= (1 << PPRX_CNT_W)) begin : g_bad_count
    $error("pprx_host: bad count parameter");
  end

  typedef enum logic [1:0] {
    PPRXH_IDLE = 2'b00,
    PPRXH_SETUP = 2'b01,
    PPRXH_STROBE = 2'b10,
    PPRXH_WAIT = 2'b11
  } pprxh_state_t;

  pprxh_state_t state;
  logic [23:0] cnt;
  logic [23:0] gap;
  logic [23:0] init_cnt;
  logic strobe_n;
  logic init_n;
  logic [7:0] data;
  logic ready;
  logic auto_n;
  logic sel_n;

  wire cnt_done = (cnt == STROBE_CYC[23:0] - PPRX_CNT_ONE);
  wire gap_ok = (gap >= GAP_CYC[23:0]);
  wire link_free = ~link.busy & init_n & gap_ok;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= PPRXH_IDLE;
      cnt <= PPRX_CNT_ZERO;
      gap <= GAP_CYC[23:0];
      strobe_n <= 1'b1;
      data <= 8'h00;
      ready <= 1'b0;
    end else begin
      ready <= 1'b0;
      if (!gap_ok) begin
        gap <= gap + PPRX_CNT_ONE;
      end
      case (state)
        PPRXH_IDLE: begin
          if (tx_valid & link_free & ~ready) begin
            // Present byte, one bit per line
            data <= tx_data;
            ready <= 1'b1;
            gap <= PPRX_CNT_ZERO;
            state <= PPRXH_SETUP;
          end
        end
        PPRXH_SETUP: begin
          strobe_n <= 1'b0;
          cnt <= PPRX_CNT_ZERO;
          state <= PPRXH_STROBE;
        end
        PPRXH_STROBE: begin
          cnt <= cnt + PPRX_CNT_ONE;
          if (cnt_done) begin
            strobe_n <= 1'b1;
            state <= PPRXH_WAIT;
          end
        end
        PPRXH_WAIT: begin
          if (~link.byte_received_pulse_n | ~link.busy) begin
            state <= PPRXH_IDLE;
          end
        end
        default: state <= PPRXH_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      init_n <= 1'b1;
      init_cnt <= PPRX_CNT_ZERO;
    end else if (init_n) begin
      init_cnt <= PPRX_CNT_ZERO;
      init_n <= ~(init_req & (state == PPRXH_IDLE));
    end else begin
      init_cnt <= init_cnt + PPRX_CNT_ONE;
      if (init_cnt == INIT_CYC[23:0]) begin
        init_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      auto_n <= 1'b1;
      sel_n <= 1'b1;
    end else begin
      auto_n <= ~auto_feed_req;
      sel_n <= ~select_req;
    end
  end

  assign link.strobe_n = strobe_n;
  assign link.data = data;
  assign link.init_n = init_n;
  assign link.auto_feed_n = auto_n;
  assign link.select_request_n = sel_n;
  assign tx_ready = ready;
endmodule

// file: tb/pprx_chk.sv
`timescale 1ns/1ns
module pprx_chk #(
  parameter int unsigned ACK_CYC = 5,
  parameter int unsigned STROBE_CYC = 1,
  parameter int unsigned INIT_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic strobe_n,
  input wire logic [7:0] data,
  input wire logic init_n,
  input wire logic byte_received_pulse_n,
  input wire logic busy,
  input wire logic paper_out,
  input wire logic error_n
);
  logic [15:0] ack_len;
  logic [15:0] stb_len;
  logic [15:0] init_len;
  // Low-time counters: the widths are too long for a bounded repetition
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_len <= 16'h0000;
      stb_len <= 16'h0000;
      init_len <= 16'h0000;
    end else begin
      ack_len <= byte_received_pulse_n ? 16'h0000 : ack_len + 16'h0001;
      stb_len <= strobe_n ? 16'h0000 : stb_len + 16'h0001;
      init_len <= init_n ? 16'h0000 : init_len + 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_ack_width: assert property ($rose(byte_received_pulse_n) |-> ack_len == 16'(ACK_CYC))
    else $error("acknowledge width wrong");
  a_busy_on_strobe: assert property (!strobe_n && !busy |=> busy)
    else $error("busy not raised on strobe");
  a_ack_in_busy: assert property (!byte_received_pulse_n |-> busy)
    else $error("busy low during acknowledge");
  a_ack_after_strobe: assert property ($rose(strobe_n) |-> ##[1:1000] !byte_received_pulse_n)
    else $error("no acknowledge after strobe");
  a_strobe_width: assert property ($rose(strobe_n) |-> stb_len >= 16'(STROBE_CYC))
    else $error("strobe too short");
  a_data_held: assert property (!strobe_n |-> $stable(data))
    else $error("data moved under strobe");
  a_init_width: assert property ($rose(init_n) |-> init_len >= 16'(INIT_CYC))
    else $error("init pulse too short");
  a_error_busy: assert property (!error_n |-> busy)
    else $error("error without busy");
  a_paper_error: assert property (paper_out |-> !error_n)
    else $error("paper out without error");
  cover property ($rose(byte_received_pulse_n));
  cover property ($rose(init_n));
  cover property ($rose(paper_out));
endmodule

// file: tb/tb_parallel_printer_receiver.sv
`timescale 1ns/1ns
module tb_parallel_printer_receiver;
  logic sys_clk, resetn, tx_valid, tx_ready, init_req, auto_feed_req, select_req;
  logic auto_feed_forced, select_forced, paper_empty, online, fault;
  logic print_valid, print_line_feed, print_ready;
  logic [7:0] tx_data, print_data;
  int error_cnt, cmp_count;
  // Shortened timing so the run stays small; all three ends share it
  localparam int unsigned TB_STROBE_CYC = 3;
  localparam int unsigned TB_INIT_CYC = 20;
  localparam int unsigned TB_GAP_CYC = 40;
  localparam int unsigned TB_ACK_CYC = 5;
  pprx_if lnk();
  pprx_host #(.STROBE_CYC(TB_STROBE_CYC), .INIT_CYC(TB_INIT_CYC), .GAP_CYC(TB_GAP_CYC)) i_pprx_host (
    .sys_clk(sys_clk), .resetn(resetn), .link(lnk), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .init_req(init_req), .auto_feed_req(auto_feed_req),
    .select_req(select_req));
  pprx_printer #(.ACK_CYC(TB_ACK_CYC), .INIT_CYC(TB_INIT_CYC)) i_pprx_printer (
    .sys_clk(sys_clk), .resetn(resetn), .link(lnk), .auto_feed_forced(auto_feed_forced),
    .select_forced(select_forced), .paper_empty(paper_empty), .online(online),
    .fault(fault), .print_data(print_data), .print_valid(print_valid),
    .print_line_feed(print_line_feed), .print_ready(print_ready));
  pprx_chk #(.ACK_CYC(TB_ACK_CYC), .STROBE_CYC(TB_STROBE_CYC), .INIT_CYC(TB_INIT_CYC)) i_pprx_chk (
    .sys_clk(sys_clk), .resetn(resetn), .strobe_n(lnk.strobe_n), .data(lnk.data),
    .init_n(lnk.init_n), .byte_received_pulse_n(lnk.byte_received_pulse_n),
    .busy(lnk.busy), .paper_out(lnk.paper_out), .error_n(lnk.error_n));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic send(input logic [7:0] d);
    int n = 0;
    @(negedge sys_clk);
    tx_data = d;
    tx_valid = 1;
    while (tx_ready !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    tx_valid = 0;
    chk("taken", {8'h00, tx_ready}, 9'h001);
  endtask
  // Takes one byte from the print port; the port stalls outside this task
  task automatic recv(input logic [8:0] exp);
    int n = 0;
    @(negedge sys_clk);
    while (print_valid !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    chk("print", {print_line_feed, print_data}, exp);
    print_ready = 1;
    @(negedge sys_clk);
    print_ready = 0;
  endtask
  // Expected as busy, paper_out, selected_status, error_n
  task automatic status(input logic [3:0] exp);
    repeat (3) @(negedge sys_clk);
    chk("status", {5'h00, lnk.busy, lnk.paper_out, lnk.selected_status, lnk.error_n},
        {5'h00, exp});
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    resetn = 0;
    tx_data = 8'h00;
    tx_valid = 0;
    init_req = 0;
    auto_feed_req = 0;
    select_req = 1;
    auto_feed_forced = 0;
    select_forced = 1;
    paper_empty = 0;
    online = 1;
    fault = 0;
    print_ready = 0;
    repeat (20) @(negedge sys_clk);
    resetn = 1;
    send(8'ha5);
    recv(9'h0a5);
    send(8'h0d);
    recv(9'h00d);
    auto_feed_req = 1;
    send(8'h0d);
    recv(9'h10d);
    auto_feed_req = 0;
    auto_feed_forced = 1;
    send(8'h0d);
    recv(9'h10d);
    auto_feed_forced = 0;
    send(8'h5a);
    send(8'h3c);
    send(8'h7e);
    repeat (100) @(negedge sys_clk);
    chk("full", {8'h00, lnk.busy}, 9'h001);
    recv(9'h05a);
    recv(9'h03c);
    recv(9'h07e);
    online = 0;
    status(4'h8);
    online = 1;
    paper_empty = 1;
    status(4'he);
    paper_empty = 0;
    fault = 1;
    status(4'ha);
    fault = 0;
    status(4'h3);
    select_forced = 0;
    select_req = 0;
    status(4'h8);
    select_req = 1;
    status(4'h3);
    send(8'h81);
    recv(9'h081);
    select_forced = 1;
    send(8'h11);
    repeat (100) @(negedge sys_clk);
    init_req = 1;
    repeat (30) @(negedge sys_clk);
    init_req = 0;
    repeat (10) @(negedge sys_clk);
    chk("flushed", {8'h00, print_valid}, 9'h000);
    send(8'h22);
    recv(9'h022);
    resetn = 0;
    status(4'h9);
    repeat (20) @(negedge sys_clk);
    resetn = 1;
    send(8'hc3);
    recv(9'h0c3);
    test_done();
  end
endmodule
